// file: verilog/dcds_params.svh
// constants for the driver chain datagram sequencer
// assumes inclusion by bare name from design files only
`ifndef DCDS_PARAMS_SVH
`define DCDS_PARAMS_SVH

// ==========================================================
// selection codes
`define DCDS_CODE_PH_A    5'h06
`define DCDS_CODE_FD_A    5'h07
`define DCDS_CODE_DAC_B0  5'h08
`define DCDS_CODE_PH_B    5'h0e
`define DCDS_CODE_FD_B    5'h0f
`define DCDS_CODE_ZERO    5'h10
`define DCDS_CODE_ONE     5'h11
`define DCDS_CODE_DIR     5'h12
`define DCDS_CODE_STEP    5'h13
`define DCDS_CODE_UNUSED  5'h14

// ==========================================================
// configuration layout
`define DCDS_CFG_WORDS    32
`define DCDS_HALF_W       6
`define DCDS_FLAG_BIT     5
`define DCDS_DAC_W        6
`define DCDS_MOTORS       3
`define DCDS_FIFO_DEPTH   32
`define DCDS_RAM_RESET    12'h000

`endif

// file: verilog/dcds_pkg.sv
// types shared by the datagram sequencer and its buffer
// assumes nothing beyond a SystemVerilog compiler
package dcds_pkg;

  typedef enum logic [1:0] {
    DCDS_IDLE  = 2'h0,
    DCDS_FETCH = 2'h1,
    DCDS_DRAIN = 2'h3
  } dcds_state_t;

  typedef struct packed {
    logic lastBit;
    logic dataBit;
  } dcds_bit_t;

endpackage : dcds_pkg

// file: verilog/dcds_stream_if.sv
// valid/ready stream between sequencer and bit buffer
// assumes both ends share sys_clk
`timescale 1ns/10ps
interface dcds_stream_if #(parameter int WIDTH = 2);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dcds_stream_if

// file: verilog/dcds_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes DEPTH is a power of two and one clock domain
`timescale 1ns/10ps
module dcds_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  dcds_stream_if.snk  inS,
  dcds_stream_if.src  outS
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             full;
  logic             empty;

  // extra pointer bit tells full from empty
  assign full       = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty      = (wrPtr_q == rdPtr_q);
  assign inS.ready  = !full;
  assign outS.valid = !empty;
  assign outS.data  = mem_q[rdPtr_q[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_q <= '0;
    end else if (inS.valid && !full) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdPtr_q <= '0;
    end else if (outS.ready && !empty) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (inS.valid && !full) begin
      mem_q[wrPtr_q[AW-1:0]] <= inS.data;
    end
  end
endmodule : dcds_fifo

// file: verilog/dcds_sequencer.sv
// driver chain datagram sequencer: snapshot, code-driven bit selection,
// bit buffer and serial shifter towards the driver chain
// assumes txRequest and motor signals come from sys_clk logic,
// linkClk is a free pin sampled here
`timescale 1ns/10ps
`include "dcds_params.svh"

module dcds_sequencer #(
  parameter int MOTORS     = `DCDS_MOTORS,
  parameter int FIFO_DEPTH = `DCDS_FIFO_DEPTH
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        txRequest,
  input  wire logic [MOTORS*`DCDS_DAC_W-1:0] coilADac,
  input  wire logic [MOTORS-1:0]           coilAPhasePolarity,
  input  wire logic [MOTORS-1:0]           coilAFastDecay,
  input  wire logic [MOTORS*`DCDS_DAC_W-1:0] coilBDac,
  input  wire logic [MOTORS-1:0]           coilBPhasePolarity,
  input  wire logic [MOTORS-1:0]           coilBFastDecay,
  input  wire logic [MOTORS-1:0]           motorDirection,
  input  wire logic [MOTORS-1:0]           motorStep,
  input  wire logic [1:0]                  lastDriverIndex,
  input  wire logic                        ramSpaceSelect,
  input  wire logic [4:0]                  hostAddr,
  input  wire logic                        hostWrite,
  input  wire logic                        hostRead,
  input  wire logic [11:0]                 hostWdata,
  output wire logic [11:0]                 hostRdata,
  input  wire logic                        linkClk,
  output wire logic                        chainClk,
  output wire logic                        chainData,
  output wire logic                        chainSelectN,
  output wire logic                        txBusy,
  output wire logic [1:0]                  driverIndex
);
  localparam int BW = $bits(dcds_pkg::dcds_bit_t);

  // ==========================================================
  // state
  dcds_pkg::dcds_state_t             state_q;
  logic [11:0]                       cfgRam_q [`DCDS_CFG_WORDS];
  logic [11:0]                       hostRdata_q;
  logic [5:0]                        fetchIdx_q;
  logic [1:0]                        motor_q;
  logic [MOTORS*`DCDS_DAC_W-1:0]     snapDacA_q;
  logic [MOTORS*`DCDS_DAC_W-1:0]     snapDacB_q;
  logic [MOTORS-1:0]                 snapPhA_q;
  logic [MOTORS-1:0]                 snapFdA_q;
  logic [MOTORS-1:0]                 snapPhB_q;
  logic [MOTORS-1:0]                 snapFdB_q;
  logic [MOTORS-1:0]                 snapDir_q;
  logic [MOTORS-1:0]                 snapStep_q;
  logic                              linkS1_q;
  logic                              linkS2_q;
  logic                              linkS3_q;
  logic                              linkLvl_q;
  logic                              linkPrev_q;
  logic                              chainClk_q;
  logic                              chainData_q;
  logic                              chainSelectN_q;
  logic                              lastSent_q;
  logic                              serDone_q;
  logic                              txBusy_q;

  logic [5:0]                        word;
  logic                              wordFlag;
  logic [4:0]                        wordCode;
  logic                              selBit;
  logic                              fetchFire;
  logic                              finalWord;
  logic                              startTx;
  logic                              linkFall;
  dcds_pkg::dcds_bit_t               pushBit;
  dcds_pkg::dcds_bit_t               popBit;

  dcds_stream_if #(.WIDTH(BW)) fillS ();
  dcds_stream_if #(.WIDTH(BW)) drainS ();

  // ==========================================================
  // signal selection
  function automatic logic dcds_pick(input logic [4:0] code, input logic [1:0] m);
    int dacIdx;
    dacIdx = int'(m) * `DCDS_DAC_W + int'(code[2:0]);
    if (code < `DCDS_CODE_PH_A) begin
      dcds_pick = snapDacA_q[dacIdx];
    end else if (code == `DCDS_CODE_PH_A) begin
      dcds_pick = snapPhA_q[m];
    end else if (code == `DCDS_CODE_FD_A) begin
      dcds_pick = snapFdA_q[m];
    end else if (code < `DCDS_CODE_PH_B) begin
      dcds_pick = snapDacB_q[dacIdx];
    end else if (code == `DCDS_CODE_PH_B) begin
      dcds_pick = snapPhB_q[m];
    end else if (code == `DCDS_CODE_FD_B) begin
      dcds_pick = snapFdB_q[m];
    end else if (code == `DCDS_CODE_ONE) begin
      dcds_pick = 1'b1;
    end else if (code == `DCDS_CODE_DIR) begin
      dcds_pick = snapDir_q[m];
    end else if (code == `DCDS_CODE_STEP) begin
      dcds_pick = snapStep_q[m];
    end else begin
      dcds_pick = 1'b0;
    end
  endfunction : dcds_pick

  // even word in the low half, odd word in the high half
  assign word      = fetchIdx_q[0] ? cfgRam_q[fetchIdx_q[5:1]][11:6]
                                   : cfgRam_q[fetchIdx_q[5:1]][5:0];
  assign wordFlag  = word[`DCDS_FLAG_BIT];
  assign wordCode  = word[4:0];
  assign selBit    = dcds_pick(wordCode, motor_q);
  assign fetchFire = (state_q == dcds_pkg::DCDS_FETCH) && fillS.ready;
  assign finalWord = wordFlag && (motor_q == lastDriverIndex);
  assign startTx   = (state_q == dcds_pkg::DCDS_IDLE) && txRequest;

  assign pushBit.lastBit = finalWord;
  assign pushBit.dataBit = selBit;
  assign fillS.valid     = (state_q == dcds_pkg::DCDS_FETCH);
  assign fillS.data      = pushBit;

  // ==========================================================
  // bit buffer
  // lets fetching run ahead of the slow link; a full buffer stalls it
  dcds_fifo #(
    .WIDTH (BW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .inS     (fillS.snk),
    .outS    (drainS.src)
  );

  // ==========================================================
  // configuration ram, host side
  // a host write and a fetch of the same word in one cycle: fetch sees old data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < `DCDS_CFG_WORDS; i++) begin
        cfgRam_q[i] <= `DCDS_RAM_RESET;
      end
    end else if (hostWrite && ramSpaceSelect) begin
      cfgRam_q[hostAddr] <= hostWdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hostRdata_q <= 12'h000;
    end else if (hostRead && ramSpaceSelect) begin
      hostRdata_q <= cfgRam_q[hostAddr];
    end
  end

  // ==========================================================
  // control
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= dcds_pkg::DCDS_IDLE;
    end else begin
      case (state_q)
        dcds_pkg::DCDS_IDLE: begin
          if (txRequest) begin
            state_q <= dcds_pkg::DCDS_FETCH;
          end
        end
        dcds_pkg::DCDS_FETCH: begin
          if (fetchFire && finalWord) begin
            state_q <= dcds_pkg::DCDS_DRAIN;
          end
        end
        dcds_pkg::DCDS_DRAIN: begin
          if (serDone_q) begin
            state_q <= dcds_pkg::DCDS_IDLE;
          end
        end
        default: begin
          state_q <= dcds_pkg::DCDS_IDLE;
        end
      endcase
    end
  end

  // wraps past the last word, so a table without a flag sends forever
  always_ff @(posedge sys_clk) begin
    if (rst || startTx) begin
      fetchIdx_q <= 6'h00;
    end else if (fetchFire) begin
      fetchIdx_q <= fetchIdx_q + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || startTx || serDone_q) begin
      motor_q <= 2'h0;
    end else if (fetchFire && wordFlag && motor_q < lastDriverIndex) begin
      motor_q <= motor_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (startTx) begin
      snapDacA_q <= coilADac;
      snapDacB_q <= coilBDac;
      snapPhA_q  <= coilAPhasePolarity;
      snapFdA_q  <= coilAFastDecay;
      snapPhB_q  <= coilBPhasePolarity;
      snapFdB_q  <= coilBFastDecay;
      snapDir_q  <= motorDirection;
      snapStep_q <= motorStep;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txBusy_q <= 1'b0;
    end else begin
      txBusy_q <= (state_q != dcds_pkg::DCDS_IDLE) || startTx;
    end
  end

  // ==========================================================
  // link clock sampling
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      linkS1_q   <= 1'b0;
      linkS2_q   <= 1'b0;
      linkS3_q   <= 1'b0;
      linkLvl_q  <= 1'b0;
      linkPrev_q <= 1'b0;
    end else begin
      linkS1_q   <= linkClk;
      linkS2_q   <= linkS1_q;
      linkS3_q   <= linkS2_q;
      linkPrev_q <= linkLvl_q;
      if (linkS2_q == linkS3_q) begin
        linkLvl_q <= linkS3_q;
      end
    end
  end

  assign linkFall = linkPrev_q && !linkLvl_q;

  // ==========================================================
  // serial shifter: data moves on the falling link edge, drivers sample on the rising one
  assign popBit       = drainS.data;
  assign drainS.ready = linkFall && !lastSent_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chainData_q    <= 1'b0;
      chainSelectN_q <= 1'b1;
      lastSent_q     <= 1'b0;
      serDone_q      <= 1'b0;
    end else begin
      serDone_q <= 1'b0;
      if (linkFall && lastSent_q) begin
        chainSelectN_q <= 1'b1;
        lastSent_q     <= 1'b0;
        serDone_q      <= 1'b1;
      end else if (linkFall && drainS.valid) begin
        chainData_q    <= popBit.dataBit;
        chainSelectN_q <= 1'b0;
        lastSent_q     <= popBit.lastBit;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chainClk_q <= 1'b0;
    end else begin
      chainClk_q <= !chainSelectN_q && linkLvl_q;
    end
  end

  assign hostRdata    = hostRdata_q;
  assign chainClk     = chainClk_q;
  assign chainData    = chainData_q;
  assign chainSelectN = chainSelectN_q;
  assign txBusy       = txBusy_q;
  assign driverIndex  = motor_q;

  // ==========================================================
  // checks
  sequence sqFinalFetch;
    fetchFire && finalWord;
  endsequence

  sequence sqPlainFetch;
    fetchFire && !wordFlag;
  endsequence

  a_idle_stays: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == dcds_pkg::DCDS_IDLE) && !txRequest |=> state_q == dcds_pkg::DCDS_IDLE)
    else $error("sequencer left idle without request");

  a_snapshot_taken: assert property (@(posedge sys_clk) disable iff (rst)
    startTx |=> snapDir_q == $past(motorDirection) && snapDacA_q == $past(coilADac))
    else $error("snapshot not taken at start");

  a_start_word: assert property (@(posedge sys_clk) disable iff (rst)
    startTx |=> fetchIdx_q == 6'h00 && motor_q == 2'h0)
    else $error("datagram did not start at word zero");

  a_motor_holds: assert property (@(posedge sys_clk) disable iff (rst)
    sqPlainFetch |=> $stable(motor_q))
    else $error("motor index moved without flag");

  a_next_motor: assert property (@(posedge sys_clk) disable iff (rst)
    fetchFire && wordFlag && (motor_q < lastDriverIndex) |=> motor_q == $past(motor_q) + 2'h1)
    else $error("motor index not advanced");

  a_final_ends: assert property (@(posedge sys_clk) disable iff (rst)
    sqFinalFetch |=> state_q == dcds_pkg::DCDS_DRAIN ##1 !fillS.valid)
    else $error("datagram did not end at last driver");

  a_index_rewind: assert property (@(posedge sys_clk) disable iff (rst)
    serDone_q |=> state_q == dcds_pkg::DCDS_IDLE && motor_q == 2'h0)
    else $error("index not rewound after datagram");

  a_fetch_order: assert property (@(posedge sys_clk) disable iff (rst)
    fetchFire && !finalWord |=> fetchIdx_q == $past(fetchIdx_q) + 6'h01)
    else $error("configuration words fetched out of order");

  a_dir_code: assert property (@(posedge sys_clk) disable iff (rst)
    fetchFire && wordCode == `DCDS_CODE_DIR |-> selBit == snapDir_q[motor_q])
    else $error("direction code picked wrong bit");

  a_unused_zero: assert property (@(posedge sys_clk) disable iff (rst)
    fetchFire && wordCode >= `DCDS_CODE_UNUSED |-> !selBit)
    else $error("unassigned code sent a one");

  a_host_write: assert property (@(posedge sys_clk) disable iff (rst)
    hostWrite && ramSpaceSelect |=> cfgRam_q[$past(hostAddr)] == $past(hostWdata))
    else $error("host write to configuration lost");

  a_select_held: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(chainSelectN_q) |-> (!chainSelectN_q)[*8] ##1 !chainSelectN_q)
    else $error("chain select dropped inside a bit");
endmodule : dcds_sequencer

// file: testbench/dcds_chain_model.sv
// receiving end of the driver chain: collects the bits of each frame
// assumes chainClk idles low and chainData is stable at its rising edge
`timescale 1ns/10ps
module dcds_chain_model (
  input wire logic chainClk,
  input wire logic chainData,
  input wire logic chainSelectN
);
  // ==========================================================
  // shift register of the chained drivers
  logic bits[$];
  int   frames;
  int   strayClk;

  initial begin
    frames   = 0;
    strayClk = 0;
  end

  // drivers shift only while selected; a clock outside a frame is noted
  always @(posedge chainClk) begin
    if (!chainSelectN) begin
      bits.push_back(chainData);
    end else begin
      strayClk++;
    end
  end

  always @(negedge chainSelectN) begin
    frames++;
  end
endmodule : dcds_chain_model

// file: testbench/testbench.sv
// self-checking bench for the datagram sequencer and a chain model
// assumes the design sources and dcds_chain_model are compiled first
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin \
  nChecks++; \
  if ((g) !== (e)) begin \
    $display("unexpected %s exp %0h got %0h", nm, e, g); \
    errTotal++; \
  end \
end
module testbench;
  localparam int LIMIT = 20000;

  logic            sys_clk;
  logic            rst;
  logic            txRequest;
  logic            linkClk;
  logic            ramSpaceSelect;
  logic            hostWrite;
  logic            hostRead;
  logic [4:0]      hostAddr;
  logic [11:0]     hostWdata;
  logic [11:0]     hostRdata;
  logic [1:0]      lastDriverIndex;
  logic [1:0]      driverIndex;
  logic [53:0]     motorIn;
  logic [17:0]     coilADac;
  logic [17:0]     coilBDac;
  logic [2:0]      coilAPhasePolarity;
  logic [2:0]      coilAFastDecay;
  logic [2:0]      coilBPhasePolarity;
  logic [2:0]      coilBFastDecay;
  logic [2:0]      motorDirection;
  logic [2:0]      motorStep;
  logic            chainClk;
  logic            chainData;
  logic            chainSelectN;
  logic            txBusy;
  logic [11:0]     mirror [32];
  logic            expQ[$];
  int              errTotal;
  int              nChecks;
  int              cycles;

  assign coilADac           = motorIn[17:0];
  assign coilBDac           = motorIn[35:18];
  assign coilAPhasePolarity = motorIn[38:36];
  assign coilAFastDecay     = motorIn[41:39];
  assign coilBPhasePolarity = motorIn[44:42];
  assign coilBFastDecay     = motorIn[47:45];
  assign motorDirection     = motorIn[50:48];
  assign motorStep          = motorIn[53:51];

  dcds_sequencer i_dut (.sys_clk, .rst, .txRequest, .coilADac, .coilAPhasePolarity, .coilAFastDecay, .coilBDac,
    .coilBPhasePolarity, .coilBFastDecay, .motorDirection, .motorStep, .lastDriverIndex, .ramSpaceSelect,
    .hostAddr, .hostWrite, .hostRead, .hostWdata, .hostRdata, .linkClk, .chainClk, .chainData, .chainSelectN,
    .txBusy, .driverIndex);

  dcds_chain_model i_chain (.chainClk, .chainData, .chainSelectN);

  // ==========================================================
  // clocks and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // odd offset keeps link edges off sys_clk edges, each one 2 ns after a sys_clk rising edge
  initial begin
    linkClk = 1'b0;
    #37;
    forever #80 linkClk = ~linkClk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errTotal++;
      endOfTest();
    end
  end

  // ==========================================================
  // access tasks
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : endOfTest

  task automatic ramWrite(input logic [4:0] a, input logic [11:0] d, input logic sel);
    @(negedge sys_clk);
    ramSpaceSelect = sel;
    hostAddr       = a;
    hostWdata      = d;
    hostWrite      = 1'b1;
    @(negedge sys_clk);
    hostWrite      = 1'b0;
    ramSpaceSelect = 1'b1;
    if (sel) begin
      mirror[a] = d;
    end
  endtask : ramWrite

  task automatic ramRead(input logic [4:0] a);
    @(negedge sys_clk);
    hostAddr = a;
    hostRead = 1'b1;
    @(negedge sys_clk);
    hostRead = 1'b0;
    `CHECK("ram readback", mirror[a], hostRdata)
  endtask : ramRead

  task automatic setWord(input int i, input logic f, input logic [4:0] c);
    logic [11:0] v;
    v = mirror[i/2];
    if (i % 2) begin
      v[11:6] = {f, c};
    end else begin
      v[5:0] = {f, c};
    end
    ramWrite(5'(i/2), v, 1'b1);
  endtask : setWord

  function automatic logic expBit(input logic [4:0] c, input int m);
    case (c) inside
      [5'h00:5'h05]: return coilADac[m*6 + c];
      5'h06:         return coilAPhasePolarity[m];
      5'h07:         return coilAFastDecay[m];
      [5'h08:5'h0d]: return coilBDac[m*6 + c - 8];
      5'h0e:         return coilBPhasePolarity[m];
      5'h0f:         return coilBFastDecay[m];
      5'h11:         return 1'b1;
      5'h12:         return motorDirection[m];
      5'h13:         return motorStep[m];
      default:       return 1'b0;
    endcase
  endfunction : expBit

  // walks the table as the chain should see it, capped for safety
  task automatic buildExp(input int lastIdx);
    int         m;
    logic [5:0] w;
    m = 0;
    expQ.delete();
    for (int i = 0; i < 64; i++) begin
      w = (i % 2) ? mirror[i/2][11:6] : mirror[i/2][5:0];
      expQ.push_back(expBit(w[4:0], m));
      if (w[5]) begin
        if (m == lastIdx) begin
          break;
        end
        m++;
      end
    end
  endtask : buildExp

  task automatic sendCheck(input logic [1:0] lastIdx);
    int n;
    buildExp(lastIdx);
    i_chain.bits.delete();
    @(negedge sys_clk);
    lastDriverIndex = lastIdx;
    txRequest       = 1'b1;
    @(negedge sys_clk);
    txRequest = 1'b0;
    motorIn   = ~motorIn;
    `CHECK("busy after request", 1'b1, txBusy)
    ramWrite(5'h1f, ~mirror[31], 1'b1);
    ramRead(5'h1f);
    txRequest = 1'b1;
    @(negedge sys_clk);
    txRequest = 1'b0;
    n = 0;
    while (txBusy !== 1'b0 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    `CHECK("datagram end", 1'b1, n < 3000)
    `CHECK("bit count", expQ.size(), i_chain.bits.size())
    foreach (expQ[k]) `CHECK("datagram bit", expQ[k], i_chain.bits[k])
    `CHECK("index rewound", 2'h0, driverIndex)
    `CHECK("select released", 1'b1, chainSelectN)
    n = i_chain.frames;
    repeat (200) @(negedge sys_clk);
    `CHECK("no extra frame", n, i_chain.frames)
  endtask : sendCheck

  // ==========================================================
  // test sequence
  initial begin
    rst             = 1'b1;
    txRequest       = 1'b0;
    ramSpaceSelect  = 1'b1;
    hostWrite       = 1'b0;
    hostRead        = 1'b0;
    hostAddr        = 5'h00;
    hostWdata       = 12'h000;
    lastDriverIndex = 2'h0;
    motorIn         = 54'h2d4c19e37a5d96;
    errTotal        = 0;
    nChecks         = 0;
    cycles          = 0;
    foreach (mirror[i]) mirror[i] = 12'h000;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (100) @(negedge sys_clk);
    `CHECK("idle busy", 1'b0, txBusy)
    `CHECK("idle select", 1'b1, chainSelectN)
    `CHECK("idle frames", 0, i_chain.frames)
    ramRead(5'h00);
    ramWrite(5'h00, 12'hfff, 1'b0);
    ramRead(5'h00);
    // every code once for the first driver, flag on the last word
    for (int i = 0; i < 32; i++) setWord(i, i == 31, 5'(i));
    ramRead(5'h0f);
    sendCheck(2'h0);
    // three fields of three bits, one per driver
    for (int m = 0; m < 3; m++) begin
      setWord(3*m, 1'b0, 5'h05);
      setWord(3*m + 1, 1'b0, 5'h12);
      setWord(3*m + 2, 1'b1, 5'h0e);
    end
    for (int l = 0; l < 3; l++) sendCheck(2'(l));
    for (int m = 0; m < 3; m++) setWord(3*m, 1'b0, 5'h11);
    sendCheck(2'h2);
    // reset clears the table, so no flag is left anywhere
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (10) @(negedge sys_clk);
    i_chain.bits.delete();
    txRequest = 1'b1;
    @(negedge sys_clk);
    txRequest = 1'b0;
    repeat (2400) @(negedge sys_clk);
    `CHECK("endless busy", 1'b1, txBusy)
    `CHECK("endless bits", 1'b1, i_chain.bits.size() > 100)
    `CHECK("stray clock", 0, i_chain.strayClk)
    endOfTest();
  end
endmodule : testbench
